// [hw/plc_top.sv]
// PCS loopback control: register slave, loopback source selection, wrap
// request for a ten-bit SerDes and the internal code-group loop.
// Assumes one clock hclk; line receive data arrives from another domain.
`timescale 1ns/1ps
`default_nettype none
module plc_top
    import plc_pkg::*;
#(
    parameter int CG_W = PLC_CG_W,
    parameter logic [4:0] PHY_ADDR_DEF = PLC_ADDR_RST
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [15:0] cfg_vec_ctrl,
    input wire logic [15:0] cfg_vec_anadv,
    input wire logic cfg_vec_valid,
    input wire logic [CG_W-1:0] tx_cg,
    input wire logic [CG_W-1:0] line_rx_cg,
    output logic [CG_W-1:0] line_tx_cg,
    output logic [CG_W-1:0] pcs_rx_cg,
    output logic serdes_wrap,
    output logic [1:0] xcvr_loop_sel
);

    // Bus address phase capture.
    logic wr_pend_reg;
    logic wr_pend_next;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_addr_next;
    logic [31:0] hrdata_next;
    // Management registers and configuration.
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [15:0] anadv_reg;
    logic [15:0] anadv_next;
    logic if_tbi_reg;
    logic if_tbi_next;
    logic src_vec_reg;
    logic src_vec_next;
    logic vec_load_reg;
    logic vec_load_next;
    logic [4:0] phy_addr_reg;
    logic [4:0] phy_addr_next;
    logic [15:0] mdio_rd_reg;
    logic [15:0] mdio_rd_next;
    logic mdio_miss_reg;
    logic mdio_miss_next;
    // Loopback state.
    logic loop_on_reg;
    logic loop_on_next;
    logic wrap_next;
    logic [CG_W-1:0] line_rx_s1_reg;
    logic [CG_W-1:0] line_rx_s2_reg;
    logic [CG_W-1:0] path_tx_cg;
    logic [CG_W-1:0] path_rx_cg;
    logic addr_ok;
    logic vec_we;
    logic wr_go;

    assign addr_ok = hsel && hready && htrans[1];
    assign wr_go = wr_pend_reg;
    assign vec_we = vec_load_reg && cfg_vec_valid;

    // The bus side never stalls: one address cycle, zero wait data phase.
    always_comb begin
        wr_pend_next = addr_ok && hwrite;
        wr_addr_next = addr_ok ? haddr[7:0] : wr_addr_reg;
        hrdata_next = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            unique case (haddr[7:0])
                PLC_CTRL_OFF: hrdata_next = {16'h0000, ctrl_reg};
                PLC_ANADV_OFF: hrdata_next = {16'h0000, anadv_reg};
                PLC_CFG_OFF: hrdata_next = {19'h0_0000, phy_addr_reg, 5'h00,
                                            vec_load_reg, src_vec_reg, if_tbi_reg};
                PLC_STAT_OFF: hrdata_next = {29'h0000_0000, mdio_miss_reg,
                                             serdes_wrap, loop_on_reg};
                PLC_MDIO_OFF: hrdata_next = {16'h0000, mdio_rd_reg};
                default: hrdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Register writes. A management frame with another address only sets the miss flag.
    always_comb begin
        ctrl_next = ctrl_reg;
        anadv_next = anadv_reg;
        if_tbi_next = if_tbi_reg;
        src_vec_next = src_vec_reg;
        vec_load_next = vec_load_reg;
        phy_addr_next = phy_addr_reg;
        mdio_rd_next = mdio_rd_reg;
        mdio_miss_next = mdio_miss_reg;
        if (vec_we) begin
            ctrl_next = cfg_vec_ctrl;
            anadv_next = cfg_vec_anadv;
        end
        if (wr_go) begin
            if (wr_addr_reg == PLC_CTRL_OFF) begin
                ctrl_next = hwdata[15:0];
            end else if (wr_addr_reg == PLC_ANADV_OFF) begin
                anadv_next = hwdata[15:0];
            end else if (wr_addr_reg == PLC_CFG_OFF) begin
                if_tbi_next = hwdata[PLC_CFG_IFSEL_BIT];
                src_vec_next = hwdata[PLC_CFG_SRCSEL_BIT];
                vec_load_next = hwdata[PLC_CFG_VECLD_BIT];
                phy_addr_next = hwdata[PLC_CFG_ADDR_LSB +: 5];
            end else if (wr_addr_reg == PLC_MDIO_OFF) begin
                if (hwdata[PLC_MDIO_ADDR_LSB +: 5] == phy_addr_reg) begin
                    mdio_miss_next = 1'b0;
                    if (hwdata[PLC_MDIO_REG_LSB +: 5] == PLC_MREG_CTRL) begin
                        if (hwdata[PLC_MDIO_WR_BIT]) begin
                            ctrl_next = hwdata[15:0];
                        end
                        mdio_rd_next = hwdata[PLC_MDIO_WR_BIT] ? hwdata[15:0] : ctrl_reg;
                    end else if (hwdata[PLC_MDIO_REG_LSB +: 5] == PLC_MREG_ANADV) begin
                        if (hwdata[PLC_MDIO_WR_BIT]) begin
                            anadv_next = hwdata[15:0];
                        end
                        mdio_rd_next = hwdata[PLC_MDIO_WR_BIT] ? hwdata[15:0] : anadv_reg;
                    end else begin
                        mdio_rd_next = 16'h0000;
                    end
                end else begin
                    mdio_miss_next = 1'b1; // Other PHY address: frame ignored, miss flagged.
                end
            end
        end
    end

    // Loopback source: the vector bit or the management control bit.
    always_comb begin
        if (src_vec_reg) begin
            loop_on_next = cfg_vec_ctrl[PLC_CTRL_LOOP_BIT];
        end else begin
            loop_on_next = ctrl_reg[PLC_CTRL_LOOP_BIT];
        end
        wrap_next = loop_on_next && if_tbi_reg;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ctrl_reg <= PLC_CTRL_RST;
            anadv_reg <= PLC_ANADV_RST;
            if_tbi_reg <= 1'b0;
            src_vec_reg <= 1'b0;
            vec_load_reg <= 1'b0;
            phy_addr_reg <= PHY_ADDR_DEF;
            mdio_rd_reg <= 16'h0000;
            mdio_miss_reg <= 1'b0;
            loop_on_reg <= 1'b0;
            serdes_wrap <= 1'b0;
            xcvr_loop_sel <= PLC_XCVR_LOOP_OFF;
            line_rx_s1_reg <= '0;
            line_rx_s2_reg <= '0;
        end else if (ce) begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata <= hrdata_next;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ctrl_reg <= ctrl_next;
            anadv_reg <= anadv_next;
            if_tbi_reg <= if_tbi_next;
            src_vec_reg <= src_vec_next;
            vec_load_reg <= vec_load_next;
            phy_addr_reg <= phy_addr_next;
            mdio_rd_reg <= mdio_rd_next;
            mdio_miss_reg <= mdio_miss_next;
            loop_on_reg <= loop_on_next;
            serdes_wrap <= wrap_next;
            xcvr_loop_sel <= PLC_XCVR_LOOP_OFF;
            line_rx_s1_reg <= line_rx_cg;
            line_rx_s2_reg <= line_rx_s1_reg;
        end
    end

    // In ten-bit mode the internal loop is never engaged; the SerDes wraps instead.
    plc_path #(
        .CG_W(CG_W)
    ) u_path (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .loop_on(loop_on_reg && !if_tbi_reg),
        .tx_cg(tx_cg),
        .line_rx_cg(line_rx_s2_reg),
        .line_tx_cg(path_tx_cg),
        .pcs_rx_cg(path_rx_cg)
    );

    assign line_tx_cg = path_tx_cg;
    assign pcs_rx_cg = path_rx_cg;

endmodule : plc_top
`default_nettype wire

// [hw/plc_pkg.sv]
// Package for the PCS loopback control block: register map, field positions,
// reset values and code-group constants.
// Assumes a single 100 MHz clock domain and an AHB-Lite register bus.
package plc_pkg;

    // Register byte offsets.
    localparam logic [7:0] PLC_CTRL_OFF = 8'h00;
    localparam logic [7:0] PLC_ANADV_OFF = 8'h04;
    localparam logic [7:0] PLC_CFG_OFF = 8'h08;
    localparam logic [7:0] PLC_STAT_OFF = 8'h0C;
    localparam logic [7:0] PLC_MDIO_OFF = 8'h10;

    // Control register (management register 0) field positions.
    localparam int PLC_CTRL_LOOP_BIT = 14;
    // Configuration register fields.
    localparam int PLC_CFG_IFSEL_BIT = 0;
    localparam int PLC_CFG_SRCSEL_BIT = 1;
    localparam int PLC_CFG_VECLD_BIT = 2;
    localparam int PLC_CFG_ADDR_LSB = 8;
    // Management frame fields: address at [25:21], register at [20:16], data at [15:0].
    localparam int PLC_MDIO_ADDR_LSB = 21;
    localparam int PLC_MDIO_REG_LSB = 16;
    localparam int PLC_MDIO_WR_BIT = 26;

    // Reset values.
    localparam logic [15:0] PLC_CTRL_RST = 16'h0000;
    localparam logic [15:0] PLC_ANADV_RST = 16'h0000;
    localparam logic [4:0] PLC_ADDR_RST = 5'h01;

    // Management register numbers that the vector may write.
    localparam logic [4:0] PLC_MREG_CTRL = 5'h00;
    localparam logic [4:0] PLC_MREG_ANADV = 5'h04;

    // Idle code group pair: K28.5 then D16.2; six ones then four here, so the pair is balanced.
    localparam logic [9:0] PLC_K28_5 = 10'h17C;
    localparam logic [9:0] PLC_D16_2 = 10'h289;

    localparam logic [1:0] PLC_XCVR_LOOP_OFF = 2'h0;
    localparam int PLC_CG_W = 10;

endpackage : plc_pkg

// [hw/plc_path.sv]
// Code-group path switch between the PCS and the transceiver.
// Assumes loop_on is a registered level in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module plc_path
    import plc_pkg::*;
#(
    parameter int CG_W = PLC_CG_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic loop_on,
    input wire logic [CG_W-1:0] tx_cg,
    input wire logic [CG_W-1:0] line_rx_cg,
    output logic [CG_W-1:0] line_tx_cg,
    output logic [CG_W-1:0] pcs_rx_cg
);

    logic idle_phase_reg;
    logic idle_phase_next;
    logic [CG_W-1:0] line_tx_next;
    logic [CG_W-1:0] pcs_rx_next;

    // Loop at the last stage; the line sees alternating Idle halves meanwhile.
    always_comb begin
        idle_phase_next = loop_on ? ~idle_phase_reg : 1'b0;
        if (loop_on) begin
            line_tx_next = idle_phase_reg ? CG_W'(PLC_D16_2) : CG_W'(PLC_K28_5);
            pcs_rx_next = tx_cg;
        end else begin
            line_tx_next = tx_cg;
            pcs_rx_next = line_rx_cg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_phase_reg <= 1'b0;
            line_tx_cg <= '0;
            pcs_rx_cg <= '0;
        end else if (ce) begin
            idle_phase_reg <= idle_phase_next;
            line_tx_cg <= line_tx_next;
            pcs_rx_cg <= pcs_rx_next;
        end
    end

endmodule : plc_path
`default_nettype wire

// [sim/plc_chk_sva.sv]
// Checker for plc_top: bus answer, loop select, path timing, idle pairs.
// Bound to plc_top by the testbench; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module plc_chk
    import plc_pkg::*;
#(parameter int CG_W = PLC_CG_W) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [CG_W-1:0] tx_cg,
    input wire logic [CG_W-1:0] line_rx_cg,
    input wire logic [CG_W-1:0] line_tx_cg,
    input wire logic [CG_W-1:0] pcs_rx_cg,
    input wire logic serdes_wrap,
    input wire logic [1:0] xcvr_loop_sel
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Four steady wrap cycles flush the receive sync flops first.
    sequence s_wrap_run;
        (serdes_wrap && ce)[*4];
    endsequence
    // Line shows an idle start that is not the delayed transmit group.
    sequence s_idle_k;
        $past(ce) && $past(line_tx_cg) == PLC_K28_5 && line_tx_cg != $past(tx_cg);
    endsequence
    AST_XCVR_ZERO: assert property (xcvr_loop_sel == 2'h0)
        else $error("loop select not zero");
    AST_READY: assert property (hreadyout)
        else $error("bus not ready");
    AST_OKAY: assert property (!hresp)
        else $error("bus response not okay");
    AST_RDATA_IDLE: assert property ($past(ce) && !$past(hsel && hready && htrans[1] && !hwrite)
        |-> hrdata == 32'h0000_0000) else $error("read data outside read");
    AST_FREEZE: assert property (!$past(ce) |-> $stable(line_tx_cg) && $stable(serdes_wrap))
        else $error("state moved while disabled");
    AST_WRAP_TX: assert property ($past(ce) && serdes_wrap && $past(serdes_wrap)
        |-> line_tx_cg == $past(tx_cg)) else $error("wrap mode altered transmit");
    AST_WRAP_RX: assert property (s_wrap_run |-> pcs_rx_cg == $past(line_rx_cg, 3))
        else $error("wrap mode altered receive");
    AST_IDLE_PAIR: assert property (s_idle_k |-> line_tx_cg == PLC_D16_2)
        else $error("idle pair broken");
endmodule : plc_chk
`default_nettype wire

// [sim/plc_serdes_model.sv]
// Ten-bit SerDes stand-in: wraps the line on request, else sends a count.
// Assumes code groups move on hclk; the count keeps received groups fresh.
`timescale 1ns/1ps
`default_nettype none
module plc_serdes_model
    import plc_pkg::*;
(
    input wire logic hclk,
    input wire logic wrap,
    input wire logic [1:0] loop_sel,
    input wire logic [PLC_CG_W-1:0] tx_in,
    output logic [PLC_CG_W-1:0] rx_out
);
    logic [PLC_CG_W-1:0] cnt_reg = 10'h000;
    // The loop is made here, not in the block, while wrap stands.
    // A nonzero loop select from user logic also wraps, bypassing the block.
    always @(posedge hclk) begin
        cnt_reg <= cnt_reg + 10'h001;
        rx_out <= (wrap || loop_sel != 2'h0) ? tx_in : cnt_reg;
    end
endmodule : plc_serdes_model
`default_nettype wire

// [sim/testbench.sv]
// Testbench for plc_top: AHB-Lite master, random code groups, SerDes model.
// Assumes checker and model compiled first; a note queue feeds the monitor.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import plc_pkg::*;
;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
    logic hclk = 1'b0;
    logic hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, serdes_wrap, cfg_vec_valid;
    logic look = 1'b0, tx_freeze = 1'b0;
    logic [1:0] htrans, xcvr_loop_sel;
    logic [2:0] hsize;
    logic [15:0] cfg_vec_ctrl, cfg_vec_anadv;
    logic [31:0] haddr, hwdata, hrdata, rnd, obs, exp_v;
    logic [31:0] notes[$];
    logic [9:0] tx_cg = 10'h000, line_rx_cg, line_tx_cg, pcs_rx_cg, prev_ltx, r;
    int mismatches = 0, checks = 0, kind = 0;
    integer seed = 32'h0000_3d2e;
    assign hready = hreadyout;
    plc_top dut_u (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .cfg_vec_ctrl, .cfg_vec_anadv, .cfg_vec_valid, .tx_cg,
        .line_rx_cg, .line_tx_cg, .pcs_rx_cg, .serdes_wrap, .xcvr_loop_sel);
    // User logic could drive the transceiver select here directly instead of the block.
    plc_serdes_model serdes_u (.hclk, .wrap(serdes_wrap), .loop_sel(xcvr_loop_sel),
        .tx_in(line_tx_cg), .rx_out(line_rx_cg));
    initial forever #5 hclk = ~hclk;
    // Random groups; 17C is kept out so data never looks like an idle start.
    always @(posedge hclk) begin
        r = 10'($random(seed));
        if (!tx_freeze) tx_cg <= (r == PLC_K28_5) ? PLC_D16_2 : r;
    end
    // Monitor: takes the oldest note whenever the driver flags a result.
    always @(posedge hclk) begin
        prev_ltx <= line_tx_cg;
        if (look && hready) begin
            case (kind)
                0: obs = hrdata;
                1: obs = {22'h0, line_tx_cg};
                2: obs = {22'h0, pcs_rx_cg};
                3: obs = {31'h0, serdes_wrap};
                default: obs = {22'h0, line_tx_cg ^ prev_ltx};
            endcase
            exp_v = notes.pop_front();
            `CHK(obs, exp_v)
        end
    end
    task automatic note(input int k, input logic [31:0] e);
        notes.push_back(e);
        kind <= k;
        look <= 1'b1;
    endtask : note
    task automatic probe(input int k, input logic [31:0] e);
        note(k, e);
        @(posedge hclk);
        look <= 1'b0;
    endtask : probe
    // One single AHB-Lite transfer; reads note d as the expected data.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h00_0000, a};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, wr ? d : 32'h0000_0000};
        if (!wr) note(0, d);
        do @(posedge hclk); while (hready !== 1'b1);
        look <= 1'b0;
    endtask : bus
    task automatic complete_run();
        if (mismatches == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    // Watchdog: the sequence needs well under a thousand cycles.
    initial begin
        #200000;
        mismatches++;
        complete_run();
    end
    initial begin
        {hresetn, hsel, hwrite, cfg_vec_valid, ce} = 5'h01;
        {htrans, hsize, haddr, hwdata, cfg_vec_ctrl, cfg_vec_anadv} = {2'h0, 3'h2, 96'h0};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, PLC_CTRL_OFF, 32'h0000_0000);
        bus(0, PLC_CFG_OFF, 32'h0000_0100);
        bus(0, 8'h14, 32'h0000_0000);
        rnd = $random(seed);
        bus(1, PLC_ANADV_OFF, rnd);
        bus(0, PLC_ANADV_OFF, {16'h0000, rnd[15:0]});
        {cfg_vec_anadv, cfg_vec_valid} <= {rnd[31:16], 1'b1};
        bus(1, PLC_CFG_OFF, 32'h0000_0104);
        bus(0, PLC_ANADV_OFF, {16'h0000, rnd[31:16]});
        {cfg_vec_ctrl, cfg_vec_valid} <= {16'h4000, 1'b0};
        bus(1, PLC_CFG_OFF, 32'h0000_0103);
        repeat (3) @(posedge hclk);
        probe(3, 1);
        bus(0, PLC_STAT_OFF, 32'h0000_0003);
        tx_freeze <= 1'b1;
        repeat (2) @(posedge hclk);
        probe(1, {22'h0, tx_cg});
        {tx_freeze, cfg_vec_ctrl} <= {1'b0, 16'h0000};
        repeat (3) @(posedge hclk);
        probe(3, 0);
        bus(1, PLC_CFG_OFF, 32'h0000_0101);
        bus(1, PLC_CTRL_OFF, 32'h0000_4000);
        repeat (8) @(posedge hclk);
        probe(3, 1);
        bus(1, PLC_CFG_OFF, 32'h0000_0100);
        repeat (4) @(posedge hclk);
        probe(4, {22'h0, PLC_K28_5 ^ PLC_D16_2});
        tx_freeze <= 1'b1;
        repeat (2) @(posedge hclk);
        probe(2, {22'h0, tx_cg});
        ce <= 1'b0;
        repeat (4) @(posedge hclk);
        ce <= 1'b1;
        bus(1, PLC_CTRL_OFF, 32'h0000_0000);
        repeat (4) @(posedge hclk);
        probe(1, {22'h0, tx_cg});
        tx_freeze <= 1'b0;
        bus(1, PLC_MDIO_OFF, 32'h04A0_4000);
        repeat (4) @(posedge hclk);
        bus(0, PLC_CTRL_OFF, 32'h0000_0000);
        bus(0, PLC_STAT_OFF, 32'h0000_0004);
        bus(1, PLC_CFG_OFF, 32'h0000_1F00);
        bus(1, PLC_MDIO_OFF, {5'h00, 1'b1, 5'h1F, PLC_MREG_ANADV, rnd[15:0]});
        repeat (4) @(posedge hclk);
        bus(0, PLC_ANADV_OFF, {16'h0000, rnd[15:0]});
        bus(0, PLC_STAT_OFF, 32'h0000_0000);
        bus(0, PLC_MDIO_OFF, {16'h0000, rnd[15:0]});
        bus(1, PLC_MDIO_OFF, {5'h00, 1'b0, 5'h1F, PLC_MREG_CTRL, 16'hFFFF});
        bus(0, PLC_MDIO_OFF, 32'h0000_0000);
        bus(0, PLC_CTRL_OFF, 32'h0000_0000);
        // Let the monitor take the last read before the verdict.
        @(posedge hclk);
        complete_run();
    end
endmodule : testbench
bind plc_top plc_chk #(.CG_W(CG_W)) chk_u (.hclk, .hresetn, .ce, .hsel, .htrans, .hwrite, .hready,
    .hrdata, .hreadyout, .hresp, .tx_cg, .line_rx_cg, .line_tx_cg, .pcs_rx_cg, .serdes_wrap,
    .xcvr_loop_sel);
`default_nettype wire
